// ==== src/fwp_top.sv ====
// Write-protection and address-decode logic of a serial NOR flash
// Behaviour
// RULE1: Address splits into 64KB sectors, 4KB subsectors
// RULE2: Modify commands need whole-byte clock counts
// RULE3: Write-enable latch must be set to modify
// RULE4: No modification during power-on reset and timer
// RULE5: Sector write-lock bit rejects program and erase
// RULE6: Lock-down bit freezes lock state until reset
// RULE7: Lock write ignored when lock-down bit set
// RULE8: All sectors locked at power-up
// RULE9: Block-protect codes protect upper sectors
// RULE10: Top/bottom set protects lower sectors instead
// RULE11: Write-protect pin low locks block-protect bits
// RULE12: Reject program/erase in protected ranges
`timescale 1ns/1ps
module fwp_top (
  // Clock and reset
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_rst,
  // Decoded command from the serial front end
  input  wire logic                        i_cmd_valid,
  input  wire fwp_pkg::fwp_cmd_t           i_cmd,
  input  wire logic [fwp_pkg::ADDR_W-1:0]  i_cmd_addr,
  input  wire logic [fwp_pkg::BIT_CNT_W-1:0] i_clk_cnt_mod8,
  input  wire logic                        i_lock_bit,
  input  wire logic                        i_lockdown_bit,
  input  wire logic                        i_regwr_bp,
  input  wire logic                        i_regwr_tb,
  input  wire logic [3:0]                  i_new_bp,
  input  wire logic                        i_new_tb,
  // Pins
  input  wire logic                        i_write_protect_n,
  // Results
  output logic                             o_cmd_accept,
  output logic                             o_cmd_reject,
  output logic                             o_wel,
  output logic                             o_por_busy,
  output logic                             o_block_protect_bit0,
  output logic                             o_block_protect_bit1,
  output logic                             o_block_protect_bit2,
  output logic                             o_block_protect_bit3,
  output logic                             o_top_bottom,
  output logic [fwp_pkg::SECT_W-1:0]       o_sector,
  output logic [fwp_pkg::SUBS_W-1:0]       o_subsector,
  output logic                             o_sect_lock,
  output logic                             o_sect_down
);
  parameter int POR_CYCLES = fwp_pkg::POR_CYC;

  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  logic wp_meta_ff;
  logic wp_sync_ff;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wp_meta_ff <= 1'b1;
      wp_sync_ff <= 1'b1;
    end else begin
      wp_meta_ff <= i_write_protect_n;
      wp_sync_ff <= wp_meta_ff;
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [fwp_pkg::SECT_W-1:0] sect_of(input logic [23:0] a);
    sect_of = a[fwp_pkg::SECT_LSB +: fwp_pkg::SECT_W]; // [RULE1]
  endfunction

  // Protected by the block-protect decode: code 0 covers none, code n from 1 to 8 covers 2^(n-1) sectors, codes 9 and up cover all
  function automatic logic bp_hit(input logic [3:0] bp, input logic tb,
                                  input logic [7:0] s);
    logic [8:0] cnt;
    logic [7:0] idx;
    cnt = 9'h000;
    idx = tb ? s : ~s; // [RULE10]
    if (bp == 4'h0) begin
      bp_hit = 1'b0;
    end else if (bp >= fwp_pkg::BP_ALL_FROM) begin
      bp_hit = 1'b1;
    end else begin
      cnt    = 9'h001 << (bp - 4'h1); // [RULE9]
      bp_hit = ({1'b0, idx} < cnt);
    end
  endfunction

  // ------------------------------------------------------------
  // Power-on timer
  // ------------------------------------------------------------
  logic [31:0] por_cnt_ff;
  logic [31:0] nxt_por_cnt;
  logic        started_ff;
  logic        por_busy;
  assign por_busy = (por_cnt_ff != 32'h00000000);
  // First edge after reset loads the full count
  always_comb begin
    nxt_por_cnt = por_busy ? por_cnt_ff - 32'h00000001 : por_cnt_ff;
    if (!started_ff) nxt_por_cnt = POR_CYCLES[31:0]; // [RULE4]
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      por_cnt_ff <= 32'h00000001;
    end else begin
      por_cnt_ff <= nxt_por_cnt;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      started_ff <= 1'b0;
    end else begin
      started_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Lock store
  // ------------------------------------------------------------
  logic [7:0] cur_sect;
  logic       mem_lock;
  logic       mem_down;
  logic       lock_wr;
  assign cur_sect = sect_of(i_cmd_addr);

  fwp_lock_mem u_lock (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_wr      (lock_wr),
    .i_wr_sect (cur_sect),
    .i_wr_lock (i_lock_bit),
    .i_wr_down (i_lockdown_bit),
    .i_rd_sect (cur_sect),
    .o_rd_lock (mem_lock),
    .o_rd_down (mem_down)
  );

  // ------------------------------------------------------------
  // Command gate
  // ------------------------------------------------------------
  // Commands are judged one cycle after presentation so the lock store
  // read is registered; the front end holds address stable for that cycle.
  logic                  pend_ff;
  fwp_pkg::fwp_cmd_t     pcmd_ff;
  logic                  wel_ff;
  logic [3:0]            bp_ff;
  logic                  tb_ff;
  logic                  acc_ff;
  logic                  rej_ff;
  logic                  nxt_wel;
  logic [3:0]            nxt_bp;
  logic                  nxt_tb;
  logic                  nxt_acc;
  logic                  nxt_rej;
  logic                  modify;
  logic                  allowed;
  logic                  byte_ok;
  logic                  bp_lock;

  assign modify  = (pcmd_ff == fwp_pkg::FWP_CMD_PROG) || (pcmd_ff == fwp_pkg::FWP_CMD_ERASE)
                || (pcmd_ff == fwp_pkg::FWP_CMD_REGWR) || (pcmd_ff == fwp_pkg::FWP_CMD_LOCKWR);
  assign byte_ok = (i_clk_cnt_mod8 == 3'h0); // [RULE2]
  assign bp_lock = !wp_sync_ff; // [RULE11]

  always_comb begin
    allowed = byte_ok && wel_ff && !por_busy; // [RULE3] [RULE4]
    unique case (pcmd_ff)
      fwp_pkg::FWP_CMD_PROG, fwp_pkg::FWP_CMD_ERASE: begin
        if (mem_lock || bp_hit(bp_ff, tb_ff, cur_sect)) allowed = 1'b0; // [RULE5] [RULE12]
      end
      fwp_pkg::FWP_CMD_LOCKWR: begin
        if (mem_down) allowed = 1'b0; // [RULE7]
      end
      fwp_pkg::FWP_CMD_REGWR: begin
        if (bp_lock && (i_regwr_bp || i_regwr_tb)) allowed = 1'b0;
      end
      fwp_pkg::FWP_CMD_NONE, fwp_pkg::FWP_CMD_WREN, fwp_pkg::FWP_CMD_WRDI: begin
        allowed = byte_ok;
      end
    endcase
  end

  assign lock_wr = pend_ff && pcmd_ff == fwp_pkg::FWP_CMD_LOCKWR && allowed;

  always_comb begin
    nxt_wel = wel_ff;
    nxt_bp  = bp_ff;
    nxt_tb  = tb_ff;
    nxt_acc = 1'b0;
    nxt_rej = 1'b0;
    if (pend_ff) begin
      nxt_acc = allowed;
      nxt_rej = !allowed;
      if (pcmd_ff == fwp_pkg::FWP_CMD_WREN && allowed) nxt_wel = 1'b1; // [RULE3]
      if (pcmd_ff == fwp_pkg::FWP_CMD_WRDI && allowed) nxt_wel = 1'b0;
      if (modify && allowed) nxt_wel = 1'b0;
      // Only the fields the write names may move, so the pin lock holds
      if (pcmd_ff == fwp_pkg::FWP_CMD_REGWR && allowed) begin
        if (i_regwr_bp) nxt_bp = i_new_bp; // [RULE11]
        if (i_regwr_tb) nxt_tb = i_new_tb;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pend_ff <= 1'b0;
      pcmd_ff <= fwp_pkg::FWP_CMD_NONE;
      wel_ff  <= 1'b0;
      bp_ff   <= 4'h0;
      tb_ff   <= 1'b0;
      acc_ff  <= 1'b0;
      rej_ff  <= 1'b0;
    end else begin
      pend_ff <= i_cmd_valid;
      pcmd_ff <= i_cmd_valid ? i_cmd : fwp_pkg::FWP_CMD_NONE;
      wel_ff  <= nxt_wel;
      bp_ff   <= nxt_bp;
      tb_ff   <= nxt_tb;
      acc_ff  <= nxt_acc;
      rej_ff  <= nxt_rej;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign o_cmd_accept         = acc_ff;
  assign o_cmd_reject         = rej_ff;
  assign o_wel                = wel_ff;
  assign o_por_busy           = por_busy;
  assign o_block_protect_bit0 = bp_ff[0];
  assign o_block_protect_bit1 = bp_ff[1];
  assign o_block_protect_bit2 = bp_ff[2];
  assign o_block_protect_bit3 = bp_ff[3];
  assign o_top_bottom         = tb_ff;
  assign o_sector             = cur_sect;
  assign o_subsector          = i_cmd_addr[fwp_pkg::SUBS_LSB +: fwp_pkg::SUBS_W]; // [RULE1]
  assign o_sect_lock          = mem_lock;
  assign o_sect_down          = mem_down;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_wel_needed: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RULE3]
    pend_ff && modify && !wel_ff |=> !acc_ff) else $error("modify accepted without wel");
  a_por_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RULE4]
    pend_ff && modify && por_busy |=> rej_ff) else $error("modify during power-on");
  a_byte_mult: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RULE2]
    pend_ff && i_clk_cnt_mod8 != 3'h0 |=> !acc_ff) else $error("partial byte accepted");
  a_lock_reject: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RULE5]
    pend_ff && pcmd_ff == fwp_pkg::FWP_CMD_PROG && mem_lock |=> rej_ff)
    else $error("locked sector programmed");
  a_down_freeze: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RULE7]
    pend_ff && pcmd_ff == fwp_pkg::FWP_CMD_LOCKWR && mem_down |=> rej_ff)
    else $error("lock write on frozen sector");
  a_bp_all: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RULE9]
    pend_ff && pcmd_ff == fwp_pkg::FWP_CMD_ERASE && bp_ff >= 4'h9 |=> rej_ff)
    else $error("erase under full protection");
  a_bp_low: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RULE10]
    pend_ff && pcmd_ff == fwp_pkg::FWP_CMD_PROG && tb_ff && bp_ff == 4'h1 && cur_sect == 8'h00
    |=> rej_ff) else $error("sector 0 not protected");
  a_bp_up: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RULE12]
    pend_ff && pcmd_ff == fwp_pkg::FWP_CMD_PROG && !tb_ff && bp_ff == 4'h8 && cur_sect[7]
    |=> rej_ff) else $error("upper half not protected");
  a_wp_pin: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RULE11]
    !wp_sync_ff && pend_ff && pcmd_ff == fwp_pkg::FWP_CMD_REGWR && i_regwr_bp
    |=> $stable(bp_ff)) else $error("bp changed while pin low");
endmodule

// ==== src/fwp_pkg.sv ====
// Shared constants for the flash write-protection block
package fwp_pkg;
  // ----------------------------------------
  // Address map
  // ----------------------------------------
  localparam int          ADDR_W       = 24;
  localparam int          SECT_W       = 8;
  localparam int          SUBS_W       = 12;
  localparam int          NUM_SECT     = 256;
  localparam int          SECT_LSB     = 16;
  localparam int          SUBS_LSB     = 12;
  localparam logic [23:0] ADDR_LAST    = 24'hFFFFFF;
  localparam logic [3:0]  BP_ALL_FROM  = 4'h9;
  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic        LOCK_RST     = 1'b1;
  localparam logic        DOWN_RST     = 1'b0;
  localparam int          CLK_MHZ      = 50;
  localparam int          POR_US       = 100;
  localparam int          POR_CYC      = POR_US * CLK_MHZ;
  localparam int          BIT_CNT_W    = 3;
  // ----------------------------------------
  // Command classes
  // ----------------------------------------
  typedef enum logic [2:0] {
    FWP_CMD_NONE, FWP_CMD_WREN, FWP_CMD_WRDI, FWP_CMD_PROG,
    FWP_CMD_ERASE, FWP_CMD_REGWR, FWP_CMD_LOCKWR
  } fwp_cmd_t;
endpackage

// ==== src/fwp_lock_mem.sv ====
// Per-sector write-lock and lock-down bit store
`timescale 1ns/1ps
module fwp_lock_mem (
  // Clock and reset
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_rst,
  // Update port
  input  wire logic                        i_wr,
  input  wire logic [fwp_pkg::SECT_W-1:0]  i_wr_sect,
  input  wire logic                        i_wr_lock,
  input  wire logic                        i_wr_down,
  // Registered read port
  input  wire logic [fwp_pkg::SECT_W-1:0]  i_rd_sect,
  output logic                             o_rd_lock,
  output logic                             o_rd_down
);
  logic [fwp_pkg::NUM_SECT-1:0] lock_ff;
  logic [fwp_pkg::NUM_SECT-1:0] down_ff;
  logic [fwp_pkg::NUM_SECT-1:0] nxt_lock;
  logic [fwp_pkg::NUM_SECT-1:0] nxt_down;
  logic                         rd_lock_ff;
  logic                         rd_down_ff;

  // Frozen sectors refuse updates here too, as a second guard
  genvar g;
  generate
    for (g = 0; g < fwp_pkg::NUM_SECT; g++) begin : g_sect
      always_comb begin
        nxt_lock[g] = lock_ff[g];
        nxt_down[g] = down_ff[g];
        if (i_wr && (i_wr_sect == fwp_pkg::SECT_W'(g)) && !down_ff[g]) begin // [RULE6]
          nxt_lock[g] = i_wr_lock;
          nxt_down[g] = i_wr_down;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      lock_ff    <= {fwp_pkg::NUM_SECT{fwp_pkg::LOCK_RST}}; // [RULE8]
      down_ff    <= {fwp_pkg::NUM_SECT{fwp_pkg::DOWN_RST}};
      rd_lock_ff <= 1'b0;
      rd_down_ff <= 1'b0;
    end else begin
      lock_ff    <= nxt_lock;
      down_ff    <= nxt_down;
      rd_lock_ff <= nxt_lock[i_rd_sect];
      rd_down_ff <= nxt_down[i_rd_sect];
    end
  end

  assign o_rd_lock = rd_lock_ff;
  assign o_rd_down = rd_down_ff;
endmodule

// ==== tb/fwp_host_model.sv ====
// Host-side model that sends decoded commands to the protection block
`timescale 1ns/1ps
module fwp_host_model (
  // Clock
  input  wire logic         i_ref_clk,
  // Command fields
  output logic              o_cmd_valid,
  output fwp_pkg::fwp_cmd_t o_cmd,
  output logic [23:0]       o_cmd_addr,
  output logic [2:0]        o_clk_cnt_mod8,
  output logic [8:0]        o_ctl,
  // Pin
  output logic              o_write_protect_n
);
  initial begin
    o_cmd_valid       = 1'b0;
    o_cmd             = fwp_pkg::FWP_CMD_NONE;
    o_cmd_addr        = 24'h000000;
    o_clk_cnt_mod8    = 3'h0;
    o_ctl             = 9'h000;
    o_write_protect_n = 1'b1;
  end
  // Fields held for take and judge cycles, then spoiled so stale use shows
  task automatic send(input fwp_pkg::fwp_cmd_t cmd, input logic [23:0] addr,
                      input logic [2:0] m8, input logic [8:0] ctl);
    @(posedge i_ref_clk);
    #1;
    o_cmd_valid    = 1'b1;
    o_cmd          = cmd;
    o_cmd_addr     = addr;
    o_clk_cnt_mod8 = m8;
    o_ctl          = ctl;
    @(posedge i_ref_clk);
    #1;
    o_cmd_valid = 1'b0;
    @(posedge i_ref_clk);
    #1;
    o_cmd_addr     = ~o_cmd_addr;
    o_clk_cnt_mod8 = ~o_clk_cnt_mod8;
    o_ctl          = ~o_ctl;
  endtask
  // Host drives the protect pin
  task automatic set_pin(input logic v);
    @(posedge i_ref_clk);
    #1;
    o_write_protect_n = v;
  endtask
endmodule

// ==== tb/tb_fwp_top.sv ====
// Self-checking bench for the flash write-protection block
`timescale 1ns/1ps
module tb_fwp_top;
  logic              i_ref_clk = 1'b0;
  logic              i_rst     = 1'b1;
  logic              cmd_valid, wp_n, acc_o, rej_o, wel, por, tbo, lck_o, dwn_o;
  fwp_pkg::fwp_cmd_t cmd;
  logic [23:0]       addr, a;
  logic [2:0]        m8, k;
  logic [8:0]        ctl;
  logic [3:0]        bp;
  logic [7:0]        sec_o, s;
  logic [11:0]       sub_o;
  logic              acc, rej, lck, dwn;
  int                mismatches  = 0;
  int                comparisons = 0;
  integer            seed        = 32'h769D1181;
  int                n, b;
  always #10 i_ref_clk = ~i_ref_clk;
  fwp_host_model fwp_host_model_inst (
    .i_ref_clk(i_ref_clk), .o_cmd_valid(cmd_valid), .o_cmd(cmd), .o_cmd_addr(addr),
    .o_clk_cnt_mod8(m8), .o_ctl(ctl), .o_write_protect_n(wp_n));
  // Short power-on count keeps the run brief
  fwp_top #(.POR_CYCLES(16)) fwp_top_inst (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
    .i_cmd_addr(addr), .i_clk_cnt_mod8(m8), .i_lock_bit(ctl[8]), .i_lockdown_bit(ctl[7]),
    .i_regwr_bp(ctl[6]), .i_regwr_tb(ctl[5]), .i_new_bp(ctl[4:1]), .i_new_tb(ctl[0]),
    .i_write_protect_n(wp_n), .o_cmd_accept(acc_o), .o_cmd_reject(rej_o), .o_wel(wel),
    .o_por_busy(por), .o_block_protect_bit0(bp[0]), .o_block_protect_bit1(bp[1]),
    .o_block_protect_bit2(bp[2]), .o_block_protect_bit3(bp[3]), .o_top_bottom(tbo),
    .o_sector(sec_o), .o_subsector(sub_o), .o_sect_lock(lck_o), .o_sect_down(dwn_o));
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic prot(input int m, input logic t, input logic [7:0] x);
    return t ? (x < m) : (x >= 256 - m);
  endfunction
  task automatic run(input fwp_pkg::fwp_cmd_t c, input logic [23:0] ad,
                     input logic [2:0] q, input logic [8:0] t);
    fork
      fwp_host_model_inst.send(c, ad, q, t);
      begin
        repeat (2) @(posedge i_ref_clk);
        check("sector", sec_o, ad[23:16]);
        check("subsector", sub_o, ad[23:12]);
        @(posedge i_ref_clk);
        #2;
        acc = acc_o;
        rej = rej_o;
        lck = lck_o;
        dwn = dwn_o;
      end
    join
  endtask
  // Write enable ahead of each modify command except the no-wel program and the final lock write
  task automatic wren(input logic [23:0] ad);
    run(fwp_pkg::FWP_CMD_WREN, ad, 3'h0, 9'h000);
  endtask
  task automatic wait_por();
    for (int i = 0; i < 64 && por !== 1'b0; i++) @(posedge i_ref_clk);
    #2;
    check("por done", por, 24'h0);
  endtask
  initial begin
    repeat (20) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    check("wel", wel, 24'h0);
    check("status", {bp, tbo}, 24'h0);
    check("por busy", por, 24'h1);
    wren(24'h000000);
    run(fwp_pkg::FWP_CMD_LOCKWR, 24'h000000, 3'h0, 9'h000);
    check("lockwr in por", rej, 24'h1);
    wait_por();
    k = 3'($random(seed)) | 3'h1;
    run(fwp_pkg::FWP_CMD_WREN, 24'hFFFFFF, k, 9'h000);
    check("wren odd bits", rej, 24'h1);
    for (int i = 0; i < 256; i++) begin
      a = {8'(i), 16'($random(seed))};
      wren(a);
      check("lock at power-up", lck, 24'h1);
      run(fwp_pkg::FWP_CMD_LOCKWR, a, 3'h0, 9'h000);
      check("lockwr", acc, 24'h1);
    end
    check("wel cleared", wel, 24'h0);
    run(fwp_pkg::FWP_CMD_PROG, a, 3'h0, 9'h000);
    check("prog no wel", rej, 24'h1);
    wren(a);
    run(fwp_pkg::FWP_CMD_PROG, a, k, 9'h000);
    check("prog odd bits", rej, 24'h1);
    wren(a);
    run(fwp_pkg::FWP_CMD_ERASE, a, 3'h0, 9'h000);
    check("erase unlocked", acc, 24'h1);
    wren(a);
    run(fwp_pkg::FWP_CMD_WRDI, a, 3'h0, 9'h000);
    check("wel after wrdi", wel, 24'h0);
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < 16; c++) begin
        wren(24'h000000);
        run(fwp_pkg::FWP_CMD_REGWR, 24'h000000, 3'h0, 9'({4'h3, 4'(c), 1'(t)}));
        check("status", {bp, tbo}, 24'({4'(c), 1'(t)}));
        n = (c == 0) ? 0 : (c >= 9) ? 256 : (1 << (c - 1));
        b = t ? n : 256 - n;
        for (int j = 0; j < 3; j++) begin
          s = (j == 2) ? 8'($random(seed)) : 8'(b - j);
          wren({s, 16'h0000});
          run((j[0] ^ t[0]) ? fwp_pkg::FWP_CMD_ERASE : fwp_pkg::FWP_CMD_PROG,
              {s, 16'($random(seed))}, 3'h0, 9'h000);
          check("protected range", acc, 24'(!prot(n, 1'(t), s)));
        end
      end
    end
    wren(24'h000000);
    run(fwp_pkg::FWP_CMD_REGWR, 24'h000000, 3'h0, 9'h060);
    wren(24'h090000);
    run(fwp_pkg::FWP_CMD_LOCKWR, 24'h090000, 3'h0, 9'h080);
    check("lock-down write", acc, 24'h1);
    wren(24'h090000);
    check("down bit", dwn, 24'h1);
    run(fwp_pkg::FWP_CMD_LOCKWR, 24'h090000, 3'h0, 9'h100);
    check("lockwr frozen", rej, 24'h1);
    wren(24'h09ABCD);
    run(fwp_pkg::FWP_CMD_PROG, 24'h09ABCD, 3'h0, 9'h000);
    check("frozen unlocked", acc, 24'h1);
    fwp_host_model_inst.set_pin(1'b0);
    repeat (4) @(posedge i_ref_clk);
    wren(24'h000000);
    run(fwp_pkg::FWP_CMD_REGWR, 24'h000000, 3'h0, 9'h067);
    check("regwr pin low", rej, 24'h1);
    check("status kept", {bp, tbo}, 24'h0);
    wren(24'h000000);
    run(fwp_pkg::FWP_CMD_REGWR, 24'h000000, 3'h0, 9'h01F);
    check("regwr other bits", acc, 24'h1);
    check("status untouched", {bp, tbo}, 24'h0);
    fwp_host_model_inst.set_pin(1'b1);
    @(posedge i_ref_clk);
    #1;
    i_rst = 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    wait_por();
    wren(24'h090000);
    check("relock on reset", lck, 24'h1);
    check("down on reset", dwn, 24'h0);
    run(fwp_pkg::FWP_CMD_PROG, 24'h090000, 3'h0, 9'h000);
    check("prog locked", rej, 24'h1);
    run(fwp_pkg::FWP_CMD_LOCKWR, 24'h090000, 3'h0, 9'h000);
    check("lockwr after reset", acc, 24'h1);
    close_out();
  end
  // Whole sequence needs about 2450 cycles
  initial begin
    #400000;
    mismatches++;
    close_out();
  end
endmodule
